// ---- core/cellmon_consts.svh ----
/*
 Constants of the cell monitor: register byte offsets, field positions,
 reset values and timing counts. Assumes a 100 MHz core_clk.
*/
// Contract
// - Only selected cell channels are converted, stepping from the highest selected down.
// - The per-channel sampling time is programmable from 4.13 us up to 1000.08 us.
// - Each channel may be oversampled up to 32 times and the average is reported.
// - A cell result above the overvoltage or below the undervoltage limit sets a fault bit.
// - Each fault source is enabled or masked on its own; only enabled ones drive the line.
// - A separate comparator bank with its own limits also flags faults onto the line.
// - Each of the eight aux channels has its own limits and flags a fault on reaching one.
// - Sixteen balancing outputs are each controlled independently of the others.
// - A balanced cell has its balancing output high; otherwise the output is low.
// - Every conversion code is 14 bits wide.
// - Up to 16 cell channels are monitored and each may be selected.
// - The fault line is active low: low while an enabled fault is set, high otherwise.
`ifndef CELLMON_CONSTS_SVH
`define CELLMON_CONSTS_SVH

// Register byte offsets
`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_CHAN_SEL    8'h08
`define OFF_SAMPLE      8'h0C
`define OFF_AVG         8'h10
`define OFF_CELL_LIM    8'h14
`define OFF_CMP_LIM     8'h18
`define OFF_BALANCE     8'h1C
`define OFF_FLT_CELL    8'h20
`define OFF_FLT_CMP     8'h24
`define OFF_FLT_AUX     8'h28
`define OFF_EN_CELL     8'h2C
`define OFF_EN_CMP      8'h30
`define OFF_EN_AUX      8'h34
`define OFF_AUX_LIM     8'h40
`define OFF_RESULT      8'h80

// Field positions
`define CTRL_START_BIT  0
`define CTRL_CONT_BIT   1
`define LIM_UV_LSB      0
`define LIM_OV_LSB      16
`define AUX_OV_LSB      8

// Reset values and the averaging limit
`define RST_CHAN_SEL    16'hFFFF
`define RST_AVG         3'h0
`define RST_UV          14'h0000
`define RST_OV          14'h3FFF
`define MAX_AVG_LOG2    3'h5

// Timing
`define CLK_NS          10
`define SAMPLE_MIN_NS   4130
`define SAMPLE_MAX_NS   1000080
`define SAMPLE_MIN_CYC  ((`SAMPLE_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define SAMPLE_MAX_CYC  (`SAMPLE_MAX_NS / `CLK_NS)

`endif

// ---- core/cellmon_pkg.sv ----
/*
 Types shared by the cell monitor files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package cellmon_pkg;
    typedef logic [13:0] code_t;
    typedef logic [3:0]  chan_t;
    typedef enum logic [1:0]
    {
        ST_IDLE    = 2'b00,
        ST_SETTLE  = 2'b01,
        ST_CONVERT = 2'b10,
        ST_STORE   = 2'b11
    } seq_state_t;
endpackage : cellmon_pkg

// ---- core/res_mem_if.sv ----
/*
 Port bundle between the sequencer and its result memory.
 Assumes one clock shared by both ends.
*/
interface res_mem_if;
    import cellmon_pkg::*;
    logic  wr_en;   // Write strobe
    chan_t wr_addr; // Written channel
    code_t wr_data; // Averaged code
    chan_t rd_addr; // Read channel
    code_t rd_data; // Registered read data
    modport seq (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
    modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : res_mem_if

// ---- core/result_mem.sv ----
/*
 Sixteen-word store of averaged cell results, registered read.
 Assumes the sequencer writes one word per finished channel.
*/
module result_mem
    import cellmon_pkg::*;
(
    input wire logic core_clk, // Core clock
    res_mem_if.mem   port      // Write and read ports
);
    code_t mem_r [16];

    // Write and registered read
    always_ff @(posedge core_clk)
    begin
        if (port.wr_en)
        begin
            mem_r[port.wr_addr] <= port.wr_data;
        end
        port.rd_data <= mem_r[port.rd_addr];
    end
endmodule : result_mem

// ---- core/cell_monitor.sv ----
/*
 Cell monitor control: conversion sequencer with averaging, limit faults,
 fault line and balancing outputs, behind a simple register port.
 Assumes the front end answers each conv_start with one conv_done pulse.
*/
`include "cellmon_consts.svh"
module cell_monitor #(
    parameter int unsigned SAMPLE_MAX_CYC = `SAMPLE_MAX_CYC
) (
    input  wire logic                core_clk,      // Core clock
    input  wire logic                reset,         // Async reset, high
    input  wire logic [7:0]          addr,          // Register byte address
    input  wire logic [31:0]         wdata,         // Write data
    input  wire logic                wr_en,         // Write strobe
    input  wire logic                rd_en,         // Read strobe
    output logic      [31:0]         rdata,         // Read data, next cycle
    output logic                     conv_start,    // Start one conversion
    output cellmon_pkg::chan_t       conv_chan,     // Channel being sampled
    input  wire logic                conv_done,     // Conversion finished
    input  wire cellmon_pkg::code_t  conv_code,     // Conversion code
    input  wire logic [15:0]         cmp_uv_hit,    // Comparator bank under
    input  wire logic [15:0]         cmp_ov_hit,    // Comparator bank over
    output cellmon_pkg::code_t       cmp_uv_level,  // Comparator under limit
    output cellmon_pkg::code_t       cmp_ov_level,  // Comparator over limit
    input  wire logic                aux_valid,     // Aux sample valid
    input  wire logic [2:0]          aux_chan,      // Aux channel
    input  wire cellmon_pkg::code_t  aux_code,      // Aux code
    output logic [15:0]              balance_drive, // Shunt switch drives
    output logic                     fault_n,       // Fault line, low active
    output logic                     busy           // Sequence running
);
    import cellmon_pkg::*;

    // Highest set bit of a channel mask
    function automatic chan_t top_chan(input logic [15:0] m);
        chan_t idx;
        idx = 4'h0;
        for (int i = 0; i < 16; i++)
        begin
            if (m[i]) idx = 4'(i);
        end
        return idx;
    endfunction : top_chan

    // One-hot mask of a channel
    function automatic logic [15:0] chan_bit(input chan_t c);
        return 16'h0001 << c;
    endfunction : chan_bit

    // Write-one-to-clear with set winning
    function automatic logic [31:0] sticky(input logic [31:0] cur,
                                           input logic [31:0] clr,
                                           input logic [31:0] set);
        return (cur & ~clr) | set;
    endfunction : sticky

    // Sampling time held inside the documented span
    function automatic logic [16:0] fit_samp(input logic [16:0] v,
                                             input logic [16:0] lo,
                                             input logic [16:0] hi);
        return (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction : fit_samp

    seq_state_t  state_r;
    chan_t       chan_r;
    logic [15:0] remain_r;
    logic [16:0] cnt_r;
    logic [18:0] acc_r;
    logic [5:0]  nsamp_r;
    logic        cont_r;
    logic [15:0] chan_sel_r;
    logic [16:0] samp_r;
    logic [2:0]  avg_r;
    code_t       cell_uv_r;
    code_t       cell_ov_r;
    logic [31:0] cell_flt_r;
    logic [31:0] cmp_flt_r;
    logic [15:0] aux_flt_r;
    logic [31:0] cell_en_r;
    logic [31:0] cmp_en_r;
    logic [15:0] aux_en_r;
    code_t       aux_uv_r [8];
    code_t       aux_ov_r [8];
    logic [31:0] rdata_r;
    logic        rd_mem_r;

    res_mem_if mem_bus ();

    result_mem u_mem (
        .core_clk (core_clk),
        .port     (mem_bus.mem)
    );

    // Register write decode
    wire         wr_ctrl   = wr_en && addr == `OFF_CTRL;
    wire         start_go  = wr_ctrl && wdata[`CTRL_START_BIT];
    wire [31:0]  cell_clr  = (wr_en && addr == `OFF_FLT_CELL) ? wdata : 32'h0;
    wire [31:0]  cmp_clr   = (wr_en && addr == `OFF_FLT_CMP) ? wdata : 32'h0;
    wire [15:0]  aux_clr   = (wr_en && addr == `OFF_FLT_AUX) ? wdata[15:0] : 16'h0;
    wire         aux_wr    = wr_en && addr[7:5] == 3'h2;
    wire [2:0]   aux_widx  = addr[4:2];

    // Sampling time held inside the documented span
    wire [16:0]  samp_min  = 17'(`SAMPLE_MIN_CYC);
    wire [16:0]  samp_max  = 17'(SAMPLE_MAX_CYC);
    wire [16:0]  samp_cyc  = fit_samp(samp_r, samp_min, samp_max);
    wire [16:0]  samp_wr   = fit_samp(wdata[16:0], samp_min, samp_max);
    wire [5:0]   avg_n     = 6'h01 << avg_r;
    wire         settled   = cnt_r == samp_cyc - 17'h00001;
    wire         last_samp = nsamp_r + 6'h01 == avg_n;
    wire code_t  avg_code  = 14'(acc_r >> avg_r);
    wire [15:0]  rem_next  = remain_r & ~chan_bit(chan_r);
    wire         storing   = state_r == ST_STORE;

    // Limit checks on the stored average and on aux samples
    wire [15:0]  cell_uv_set = (storing && avg_code < cell_uv_r) ? chan_bit(chan_r) : 16'h0;
    wire [15:0]  cell_ov_set = (storing && avg_code > cell_ov_r) ? chan_bit(chan_r) : 16'h0;
    wire [7:0]   aux_onehot  = 8'h01 << aux_chan;
    wire [7:0]   aux_uv_set  = (aux_valid && aux_code <= aux_uv_r[aux_chan]) ?
                               aux_onehot : 8'h00;
    wire [7:0]   aux_ov_set  = (aux_valid && aux_code >= aux_ov_r[aux_chan]) ?
                               aux_onehot : 8'h00;
    wire [31:0]  cell_flt_nxt = sticky(cell_flt_r, cell_clr,
                                       {cell_ov_set, cell_uv_set});
    wire [31:0]  cmp_flt_nxt  = sticky(cmp_flt_r, cmp_clr,
                                       {cmp_ov_hit, cmp_uv_hit});
    wire [31:0]  aux_flt_nxt  = sticky({16'h0, aux_flt_r}, {16'h0, aux_clr},
                                       {16'h0, aux_ov_set, aux_uv_set});
    wire         fault_any = |(cell_flt_r & cell_en_r) | |(cmp_flt_r & cmp_en_r) |
                             |(aux_flt_r & aux_en_r);

    // Result memory hookup
    assign mem_bus.wr_en   = storing;
    assign mem_bus.wr_addr = chan_r;
    assign mem_bus.wr_data = avg_code;
    assign mem_bus.rd_addr = addr[5:2];
    assign rdata           = rd_mem_r ? {18'h0, mem_bus.rd_data} : rdata_r;

    // Read data selection
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0;
        case (addr)
            `OFF_CTRL:     rd_mux = {30'h0, cont_r, 1'b0};
            `OFF_STATUS:   rd_mux = {16'h0, remain_r[11:0], chan_r} | {busy, 31'h0};
            `OFF_CHAN_SEL: rd_mux = {16'h0, chan_sel_r};
            `OFF_SAMPLE:   rd_mux = {15'h0, samp_r};
            `OFF_AVG:      rd_mux = {29'h0, avg_r};
            `OFF_CELL_LIM: rd_mux = {2'h0, cell_ov_r, 2'h0, cell_uv_r};
            `OFF_CMP_LIM:  rd_mux = {2'h0, cmp_ov_level, 2'h0, cmp_uv_level};
            `OFF_BALANCE:  rd_mux = {16'h0, balance_drive};
            `OFF_FLT_CELL: rd_mux = cell_flt_r;
            `OFF_FLT_CMP:  rd_mux = cmp_flt_r;
            `OFF_FLT_AUX:  rd_mux = {16'h0, aux_flt_r};
            `OFF_EN_CELL:  rd_mux = cell_en_r;
            `OFF_EN_CMP:   rd_mux = cmp_en_r;
            `OFF_EN_AUX:   rd_mux = {16'h0, aux_en_r};
            default:
            begin
                if (addr[7:5] == 3'h2)
                    rd_mux = {2'h0, aux_ov_r[aux_widx], 2'h0, aux_uv_r[aux_widx]};
            end
        endcase
    end

    // Register bus and configuration
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rdata_r <= 32'h0; rd_mem_r <= 1'b0; cont_r <= 1'b0;
            chan_sel_r <= `RST_CHAN_SEL; samp_r <= 17'(`SAMPLE_MIN_CYC);
            avg_r <= `RST_AVG; cell_uv_r <= `RST_UV; cell_ov_r <= `RST_OV;
            cmp_uv_level <= `RST_UV; cmp_ov_level <= `RST_OV; balance_drive <= 16'h0;
            cell_en_r <= 32'h0; cmp_en_r <= 32'h0; aux_en_r <= 16'h0;
            for (int i = 0; i < 8; i++)
            begin
                aux_uv_r[i] <= `RST_UV;
                aux_ov_r[i] <= `RST_OV;
            end
        end
        else
        begin
            rdata_r  <= rd_en ? rd_mux : 32'h0;
            rd_mem_r <= rd_en && addr[7:6] == 2'h2;
            if (wr_ctrl) cont_r <= wdata[`CTRL_CONT_BIT];
            if (wr_en && addr == `OFF_CHAN_SEL) chan_sel_r <= wdata[15:0];
            if (wr_en && addr == `OFF_SAMPLE) samp_r <= samp_wr;
            if (wr_en && addr == `OFF_AVG)
                avg_r <= (wdata[2:0] > `MAX_AVG_LOG2) ? `MAX_AVG_LOG2 : wdata[2:0];
            if (wr_en && addr == `OFF_CELL_LIM)
            begin
                cell_uv_r <= wdata[`LIM_UV_LSB +: 14];
                cell_ov_r <= wdata[`LIM_OV_LSB +: 14];
            end
            if (wr_en && addr == `OFF_CMP_LIM)
            begin
                cmp_uv_level <= wdata[`LIM_UV_LSB +: 14];
                cmp_ov_level <= wdata[`LIM_OV_LSB +: 14];
            end
            if (wr_en && addr == `OFF_BALANCE) balance_drive <= wdata[15:0];
            if (wr_en && addr == `OFF_EN_CELL) cell_en_r <= wdata;
            if (wr_en && addr == `OFF_EN_CMP) cmp_en_r <= wdata;
            if (wr_en && addr == `OFF_EN_AUX) aux_en_r <= wdata[15:0];
            if (aux_wr)
            begin
                aux_uv_r[aux_widx] <= wdata[`LIM_UV_LSB +: 14];
                aux_ov_r[aux_widx] <= wdata[`LIM_OV_LSB +: 14];
            end
        end
    end

    // Sticky fault bits and fault line
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            cell_flt_r <= 32'h0; cmp_flt_r <= 32'h0; aux_flt_r <= 16'h0;
            fault_n <= 1'b1;
        end
        else
        begin
            cell_flt_r <= cell_flt_nxt;
            cmp_flt_r  <= cmp_flt_nxt;
            aux_flt_r  <= aux_flt_nxt[15:0];
            fault_n    <= ~fault_any;
        end
    end

    // Conversion sequencer, highest selected channel first
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            state_r <= ST_IDLE; chan_r <= 4'h0; remain_r <= 16'h0; cnt_r <= 17'h0;
            acc_r <= 19'h0; nsamp_r <= 6'h0; conv_start <= 1'b0; busy <= 1'b0;
        end
        else
        begin
            conv_start <= 1'b0;
            case (state_r)
                ST_IDLE:
                begin
                    if (start_go && chan_sel_r != 16'h0)
                    begin
                        remain_r <= chan_sel_r;
                        chan_r <= top_chan(chan_sel_r);
                        cnt_r <= 17'h0; acc_r <= 19'h0; nsamp_r <= 6'h0;
                        busy <= 1'b1; state_r <= ST_SETTLE;
                    end
                end
                ST_SETTLE:
                begin
                    cnt_r <= cnt_r + 17'h00001;
                    if (settled)
                    begin
                        conv_start <= 1'b1;
                        state_r <= ST_CONVERT;
                    end
                end
                ST_CONVERT:
                begin
                    if (conv_done)
                    begin
                        acc_r <= acc_r + {5'h00, conv_code};
                        nsamp_r <= nsamp_r + 6'h01;
                        cnt_r <= 17'h0;
                        state_r <= last_samp ? ST_STORE : ST_SETTLE;
                    end
                end
                ST_STORE:
                begin
                    acc_r <= 19'h0; nsamp_r <= 6'h0; cnt_r <= 17'h0;
                    if (rem_next != 16'h0)
                    begin
                        remain_r <= rem_next;
                        chan_r <= top_chan(rem_next);
                        state_r <= ST_SETTLE;
                    end
                    else if (cont_r && chan_sel_r != 16'h0)
                    begin
                        remain_r <= chan_sel_r;
                        chan_r <= top_chan(chan_sel_r);
                        state_r <= ST_SETTLE;
                    end
                    else
                    begin
                        remain_r <= 16'h0; busy <= 1'b0; state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    assign conv_chan = chan_r;

    // Checks
    wire [31:0] keep_cell = cell_flt_r & ~cell_clr;
    sequence s_store_more;
        state_r == ST_STORE && rem_next != 16'h0;
    endsequence
    sequence s_ov_result;
        state_r == ST_STORE && avg_code > cell_ov_r;
    endsequence

    AST_DESCEND: assert property (@(posedge core_clk) disable iff (reset)
        s_store_more |=> chan_r < $past(chan_r)) else $error("channel order not descending");
    AST_SELECTED: assert property (@(posedge core_clk) disable iff (reset)
        conv_start |-> remain_r[chan_r]) else $error("unselected channel converted");
    AST_SAMPLE_SPAN: assert property (@(posedge core_clk) disable iff (reset)
        $rose(conv_start) |-> $past(cnt_r) + 17'h00001 == samp_cyc
        && samp_cyc >= samp_min && samp_cyc <= samp_max) else $error("bad sampling time");
    AST_AVG_COUNT: assert property (@(posedge core_clk) disable iff (reset)
        state_r == ST_STORE |-> nsamp_r == avg_n) else $error("wrong sample count");
    AST_CELL_OV: assert property (@(posedge core_clk) disable iff (reset)
        s_ov_result |=> cell_flt_r[16 + $past(chan_r)]) else $error("over fault not set");
    AST_CMP_BANK: assert property (@(posedge core_clk) disable iff (reset)
        1'b1 |=> (cmp_flt_r & $past({cmp_ov_hit, cmp_uv_hit})) ==
        $past({cmp_ov_hit, cmp_uv_hit})) else $error("comparator fault missed");
    AST_AUX_OV: assert property (@(posedge core_clk) disable iff (reset)
        aux_valid && aux_code >= aux_ov_r[aux_chan] |=> aux_flt_r[8 + $past(aux_chan)])
        else $error("aux fault missed");
    AST_BALANCE: assert property (@(posedge core_clk) disable iff (reset)
        wr_en && addr == `OFF_BALANCE |=> balance_drive == $past(wdata[15:0]))
        else $error("balance drive wrong");
    AST_LINE_LOW: assert property (@(posedge core_clk) disable iff (reset)
        1'b1 |=> fault_n == !$past(fault_any))
        else $error("fault line not tracking");
    AST_MASKED: assert property (@(posedge core_clk) disable iff (reset)
        !fault_any |=> fault_n) else $error("masked fault drove line");
    AST_STICKY: assert property (@(posedge core_clk) disable iff (reset)
        1'b1 |=> (cell_flt_r & $past(keep_cell)) == $past(keep_cell))
        else $error("fault bit lost without clear");
endmodule : cell_monitor

// ---- tb/fe_model.sv ----
/*
 Converter front end model: answers each conv_start with one conv_done
 pulse and a code from a fixed per-channel table, 2 higher on every second answer.
 Assumes the monitor drives conv_start and conv_chan from core_clk.
*/
module fe_model
    import cellmon_pkg::*;
(
    input  wire logic                core_clk,   // Core clock
    input  wire logic                reset,      // Async reset, high
    input  wire logic                conv_start, // Conversion request
    input  wire cellmon_pkg::chan_t  conv_chan,  // Sampled channel
    output logic                     conv_done,  // Conversion finished
    output cellmon_pkg::code_t       conv_code   // Conversion code
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       pend;
    logic       odd;
    logic [2:0] cnt;
    chan_t      ch;

    // Cell level per channel, 14-bit codes
    function automatic code_t base(input chan_t c);
        case (c)
            4'hF:    base = 14'h3100;
            4'h2:    base = 14'h0080;
            default: base = 14'h1000;
        endcase
    endfunction : base

    // Answer promptly then slowly; second sample of a pair is 2 higher
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            pend <= 1'b0; odd <= 1'b0; cnt <= 3'h0;
            ch <= 4'h0; conv_done <= 1'b0; conv_code <= 14'h0000;
        end
        else
        begin
            conv_done <= 1'b0;
            if (pend && cnt == 3'h0)
            begin
                conv_done <= 1'b1;
                conv_code <= base(ch) + (odd ? 14'h0002 : 14'h0000);
                pend      <= 1'b0;
                odd       <= ~odd;
            end
            else if (pend)
                cnt <= cnt - 3'h1;
            else
                conv_code <= ~conv_code; // No valid code outside done
            if (conv_start)
            begin
                pend <= 1'b1;
                ch   <= conv_chan;
                cnt  <= odd ? 3'h4 : 3'h0;
            end
        end
    end
endmodule : fe_model

// ---- tb/tb_top.sv ----
/*
 Self-checking bench of the cell monitor: register tasks, sequences of
 accesses with expected values. Assumes the front end model beside it.
*/
`include "cellmon_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cellmon_pkg::*;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [31:0] rdata;
    logic        conv_start, conv_done, busy, fault_n, aux_valid = 1'b0;
    chan_t       conv_chan;
    code_t       conv_code, cmp_uv_level, cmp_ov_level, aux_code = 14'h0000;
    logic [15:0] cmp_uv_hit = 16'h0, cmp_ov_hit = 16'h0, balance_drive;
    logic [2:0]  aux_chan = 3'h0;
    int          miscompares = 0, compares = 0, cycles = 0, n;
    chan_t       order[$];

    cell_monitor #(.SAMPLE_MAX_CYC(500)) cell_monitor_i (.core_clk(core_clk),
        .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .conv_start(conv_start), .conv_chan(conv_chan),
        .conv_done(conv_done), .conv_code(conv_code), .cmp_uv_hit(cmp_uv_hit),
        .cmp_ov_hit(cmp_ov_hit), .cmp_uv_level(cmp_uv_level),
        .cmp_ov_level(cmp_ov_level), .aux_valid(aux_valid), .aux_chan(aux_chan),
        .aux_code(aux_code), .balance_drive(balance_drive), .fault_n(fault_n),
        .busy(busy));
    fe_model fe_model_i (.core_clk(core_clk), .reset(reset), .conv_start(conv_start),
        .conv_chan(conv_chan), .conv_done(conv_done), .conv_code(conv_code));

    // Clock and conversion order record
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles++;
        if (conv_start === 1'b1) order.push_back(conv_chan);
        if (cycles == 20000)
        begin
            miscompares++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a; wdata <= d; wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        addr <= a; rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 d = rdata;
        @(posedge core_clk);
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask : rchk

    task automatic settle_line();
        repeat (2) @(posedge core_clk);
    endtask : settle_line

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask : end_test

    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    // Main sequence
    initial
    begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        chk({fault_n, balance_drive}, 17'h10000);
        chk({cmp_uv_level, cmp_ov_level}, 28'h0003FFF);
        rchk(`OFF_CHAN_SEL, 32'h0000FFFF);
        rchk(8'h3C, 32'h0); // Unmapped place reads zero
        wr(`OFF_AVG, 32'h7);
        rchk(`OFF_AVG, 32'h5);
        wr(`OFF_SAMPLE, 32'h1FFFF);
        rchk(`OFF_SAMPLE, 32'd500);
        wr(`OFF_SAMPLE, 32'h0);
        rchk(`OFF_SAMPLE, 32'd413);
        end_test("reset");
        // Three channels, two samples each, strict limits
        wr(`OFF_CHAN_SEL, 32'h8005);
        wr(`OFF_AVG, 32'h1);
        wr(`OFF_CELL_LIM, 32'h30000100);
        wr(`OFF_CTRL, 32'h1);
        n = 0;
        while (conv_start !== 1'b1 && n < 1000)
        begin
            @(posedge core_clk);
            #1 n++;
        end
        chk(n >= 412 && n <= 416, 1'b1);
        n = 0;
        while (busy !== 1'b0 && n < 5000)
        begin
            @(posedge core_clk);
            n++;
        end
        chk(busy, 1'b0);
        chk(order.size(), 6);
        foreach (order[i]) chk(order[i], (i < 2) ? 4'hF : (i < 4) ? 4'h2 : 4'h0);
        rchk(`OFF_RESULT + 8'h3C, 32'h3101);
        rchk(`OFF_RESULT + 8'h08, 32'h0081);
        rchk(`OFF_RESULT, 32'h1001);
        end_test("sequence");
        rchk(`OFF_FLT_CELL, 32'h80000004);
        chk(fault_n, 1'b1);
        wr(`OFF_EN_CELL, 32'h80000000);
        settle_line();
        chk(fault_n, 1'b0);
        wr(`OFF_FLT_CELL, 32'h80000000);
        settle_line();
        chk(fault_n, 1'b1);
        rchk(`OFF_FLT_CELL, 32'h00000004);
        end_test("cell_faults");
        // Comparator bank with its own limits
        wr(`OFF_CMP_LIM, 32'h2AAA0555);
        chk({cmp_uv_level, cmp_ov_level}, {14'h0555, 14'h2AAA});
        cmp_uv_hit <= 16'h0020;
        @(posedge core_clk);
        cmp_uv_hit <= 16'h0;
        settle_line();
        chk(fault_n, 1'b1);
        rchk(`OFF_FLT_CMP, 32'h00000020);
        wr(`OFF_EN_CMP, 32'h00000020);
        settle_line();
        chk(fault_n, 1'b0);
        wr(`OFF_FLT_CMP, 32'h00000020);
        settle_line();
        chk(fault_n, 1'b1);
        end_test("comparators");
        // Aux limits are reached inclusively
        wr(`OFF_AUX_LIM + 8'h0C, 32'h00200010);
        aux_chan <= 3'h3; aux_code <= 14'h0020; aux_valid <= 1'b1;
        @(posedge core_clk);
        aux_code <= 14'h0010;
        @(posedge core_clk);
        aux_valid <= 1'b0;
        settle_line();
        rchk(`OFF_FLT_AUX, 32'h00000808);
        wr(`OFF_EN_AUX, 32'h00000800);
        settle_line();
        chk(fault_n, 1'b0);
        end_test("aux");
        // Independent balancing outputs
        wr(`OFF_BALANCE, 32'hA5C3);
        chk(balance_drive, 16'hA5C3);
        wr(`OFF_BALANCE, 32'h8001);
        chk(balance_drive, 16'h8001);
        wr(`OFF_BALANCE, 32'h0);
        chk(balance_drive, 16'h0000);
        end_test("balance");
        // Continuous mode repeats the selection until cleared
        wr(`OFF_CHAN_SEL, 32'h0001);
        wr(`OFF_AVG, 32'h0);
        wr(`OFF_CTRL, 32'h3);
        order.delete();
        rchk(`OFF_CTRL, 32'h2);
        rchk(`OFF_STATUS, 32'h80000010);
        repeat (1000) @(posedge core_clk);
        chk(order.size(), 2);
        chk(order[0], 4'h0);
        wr(`OFF_CTRL, 32'h0);
        n = 0;
        while (busy !== 1'b0 && n < 1000)
        begin
            @(posedge core_clk);
            n++;
        end
        chk(busy, 1'b0);
        end_test("continuous");
        stop_test();
    end
endmodule : tb_top
